// ---- core/clock_range_power_config_regs.sv ----
// clock input, supply quieting, full-scale and power profile register bank
`timescale 1ns/1ps
module clock_range_power_config_regs
  import clock_range_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire reg_request_type reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [POS_W-1:0] edge_position_word,
  input wire logic edge_position_strobe,
  input wire logic [TAP_COUNT-1:0] alignment_taps,
  output analog_controls_type controls,
  output logic alignment_level,
  output logic alignment_rise
);
  logic [7:0] alignment_control;
  logic [7:0] clock_input_config;
  logic [7:0] supply_noise_control;
  logic [POS_W-1:0] alignment_edge_position;
  logic [FS_W-1:0] full_scale_code;
  logic [7:0] power_profile_a;

  logic [7:0] next_alignment_control;
  logic [7:0] next_clock_input_config;
  logic [7:0] next_supply_noise_control;
  logic [POS_W-1:0] next_alignment_edge_position;
  logic [FS_W-1:0] next_full_scale_code;
  logic [7:0] next_power_profile_a;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base);
    hit = (a == base);
  endfunction

  // reserved fields are stored as written; keeping them at default is the host's duty
  always_comb begin
    next_alignment_control = alignment_control;
    next_clock_input_config = clock_input_config;
    next_supply_noise_control = supply_noise_control;
    next_full_scale_code = full_scale_code;
    next_power_profile_a = power_profile_a;
    next_alignment_edge_position = alignment_edge_position;
    if (edge_position_strobe) begin
      next_alignment_edge_position = edge_position_word;
    end
    if (reg_req.wr) begin
      if (hit(reg_req.addr, ALIGN_CONTROL_ADDR)) begin
        next_alignment_control = reg_req.wdata;
      end
      if (hit(reg_req.addr, CLOCK_INPUT_CONFIG_ADDR)) begin
        next_clock_input_config = reg_req.wdata;
      end
      if (hit(reg_req.addr, SUPPLY_NOISE_CONTROL_ADDR)) begin
        next_supply_noise_control = reg_req.wdata;
      end
      if (hit(reg_req.addr, FULL_SCALE_CODE_ADDR)) begin
        next_full_scale_code[7:0] = reg_req.wdata;
      end
      if (hit(reg_req.addr, FULL_SCALE_CODE_ADDR + 15'h001)) begin
        next_full_scale_code[15:8] = reg_req.wdata;
      end
      // reserved codes are dropped so analog bias never sees an untested profile
      if (hit(reg_req.addr, POWER_PROFILE_A_ADDR)
          && (reg_req.wdata == POWER_CODE_LOW || reg_req.wdata == POWER_CODE_HIGH_PERF)) begin
        next_power_profile_a = reg_req.wdata;
      end
      // edge position offsets take no write at all
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ALIGN_CONTROL_ADDR: next_rdata = alignment_control;
        CLOCK_INPUT_CONFIG_ADDR: next_rdata = clock_input_config;
        SUPPLY_NOISE_CONTROL_ADDR: next_rdata = supply_noise_control;
        EDGE_POSITION_ADDR: next_rdata = alignment_edge_position[7:0];
        EDGE_POSITION_ADDR + 15'h001: next_rdata = alignment_edge_position[15:8];
        EDGE_POSITION_ADDR + 15'h002: next_rdata = alignment_edge_position[23:16];
        FULL_SCALE_CODE_ADDR: next_rdata = full_scale_code[7:0];
        FULL_SCALE_CODE_ADDR + 15'h001: next_rdata = full_scale_code[15:8];
        POWER_PROFILE_A_ADDR: next_rdata = power_profile_a;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      alignment_control <= ALIGN_CONTROL_RESET;
      clock_input_config <= CLOCK_INPUT_CONFIG_RESET;
      supply_noise_control <= SUPPLY_NOISE_CONTROL_RESET;
      alignment_edge_position <= EDGE_POSITION_RESET;
      full_scale_code <= FULL_SCALE_CODE_RESET;
      power_profile_a <= POWER_PROFILE_A_RESET;
      reg_rdata <= 8'h00;
    end else begin
      alignment_control <= next_alignment_control;
      clock_input_config <= next_clock_input_config;
      supply_noise_control <= next_supply_noise_control;
      alignment_edge_position <= next_alignment_edge_position;
      full_scale_code <= next_full_scale_code;
      power_profile_a <= next_power_profile_a;
      reg_rdata <= next_rdata;
    end
  end

  always_comb begin
    controls.clock_input_pecl_select = clock_input_config[CLOCK_PECL_BIT];
    controls.alignment_input_pecl_select = clock_input_config[ALIGN_PECL_BIT];
    controls.analog_rail_quiet_enable = supply_noise_control[ANALOG_RAIL_QUIET_BIT];
    controls.clock_rail_quiet_enable = supply_noise_control[CLOCK_RAIL_QUIET_BIT];
    controls.low_power_select = (power_profile_a == POWER_CODE_LOW);
    controls.full_scale_code = full_scale_code;
  end

  alignment_tap_select u_tap (
    .clk(clk),
    .rstn(rstn),
    .alignment_taps(alignment_taps),
    .alignment_delay_select(alignment_control[DELAY_SEL_LSB +: SEL_W]),
    .alignment_polarity_invert(clock_input_config[INVERT_BIT]),
    .alignment_level(alignment_level),
    .alignment_rise(alignment_rise)
  );

  a_clock_pecl_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == CLOCK_INPUT_CONFIG_ADDR
    |=> controls.clock_input_pecl_select == $past(reg_req.wdata[2]))
    else $error("clock PECL select does not follow config write");

  a_align_pecl_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == CLOCK_INPUT_CONFIG_ADDR
    |=> controls.alignment_input_pecl_select == $past(reg_req.wdata[1]))
    else $error("alignment PECL select does not follow config write");

  a_analog_quiet_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == SUPPLY_NOISE_CONTROL_ADDR
    |=> controls.analog_rail_quiet_enable == $past(reg_req.wdata[2]))
    else $error("analog rail quiet enable does not follow write");

  a_clock_quiet_write: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == SUPPLY_NOISE_CONTROL_ADDR
    |=> controls.clock_rail_quiet_enable == $past(reg_req.wdata[0]))
    else $error("clock rail quiet enable does not follow write");

  a_full_scale_high: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == FULL_SCALE_CODE_ADDR + 15'h001
    |=> controls.full_scale_code[15:8] == $past(reg_req.wdata))
    else $error("full-scale upper byte not written");

  a_power_reserved: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == POWER_PROFILE_A_ADDR
    && reg_req.wdata != POWER_CODE_LOW && reg_req.wdata != POWER_CODE_HIGH_PERF
    |=> $stable(power_profile_a))
    else $error("reserved power profile code was accepted");

  a_position_capture: assert property (@(posedge clk) disable iff (!rstn)
    edge_position_strobe ##1 (reg_req.rd && reg_req.addr == EDGE_POSITION_ADDR + 15'h002
    && !edge_position_strobe) |=> reg_rdata == $past(edge_position_word[23:16], 2))
    else $error("edge position read does not return captured value");

  a_position_readonly: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && !edge_position_strobe |=> $stable(alignment_edge_position))
    else $error("edge position changed on host write");

  a_position_hold: assert property (@(posedge clk) disable iff (!rstn)
    !edge_position_strobe |=> $stable(alignment_edge_position))
    else $error("edge position changed without a capture strobe");

  a_position_low_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.rd && reg_req.addr == EDGE_POSITION_ADDR
    |=> reg_rdata == $past(alignment_edge_position[7:0]))
    else $error("edge position low byte read mismatch");

  a_full_scale_low: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == FULL_SCALE_CODE_ADDR
    |=> controls.full_scale_code[7:0] == $past(reg_req.wdata))
    else $error("full-scale lower byte not written");

  // each byte lands alone, so a low byte write must leave the high byte untouched
  a_full_scale_pair: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == FULL_SCALE_CODE_ADDR
    |=> $stable(controls.full_scale_code[15:8]))
    else $error("full-scale upper byte disturbed by lower byte write");

  a_full_scale_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_req.wr && (reg_req.addr == FULL_SCALE_CODE_ADDR
    || reg_req.addr == FULL_SCALE_CODE_ADDR + 15'h001)) |=> $stable(full_scale_code))
    else $error("full-scale code changed without a write");

  a_full_scale_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.rd && reg_req.addr == FULL_SCALE_CODE_ADDR + 15'h001
    |=> reg_rdata == $past(full_scale_code[15:8]))
    else $error("full-scale upper byte read mismatch");

  a_power_accept: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == POWER_PROFILE_A_ADDR
    && (reg_req.wdata == POWER_CODE_LOW || reg_req.wdata == POWER_CODE_HIGH_PERF)
    |=> power_profile_a == $past(reg_req.wdata))
    else $error("legal power profile code was not stored");

  a_low_power_mode: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.wr && reg_req.addr == POWER_PROFILE_A_ADDR && reg_req.wdata == POWER_CODE_LOW
    |=> controls.low_power_select)
    else $error("low power select not raised after low power code");

  a_power_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.rd && reg_req.addr == POWER_PROFILE_A_ADDR
    |=> reg_rdata == $past(power_profile_a))
    else $error("power profile read mismatch");

  a_config_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_req.wr && reg_req.addr == CLOCK_INPUT_CONFIG_ADDR) |=> $stable(clock_input_config))
    else $error("clock input config changed without a write");

  a_config_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_req.rd && reg_req.addr == CLOCK_INPUT_CONFIG_ADDR
    |=> reg_rdata == $past(clock_input_config))
    else $error("clock input config read mismatch");

  a_supply_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(reg_req.wr && reg_req.addr == SUPPLY_NOISE_CONTROL_ADDR)
    |=> $stable(supply_noise_control))
    else $error("supply noise control changed without a write");

  // an idle read port must show zero so a stale byte is never taken as fresh data
  a_read_idle: assert property (@(posedge clk) disable iff (!rstn)
    !reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data not zero in a cycle without a read");
endmodule

// ---- shared/clock_range_pkg.sv ----
// constants and carrier types for the clock, range and power configuration registers
package clock_range_pkg;
  localparam int ADDR_W = 15;
  localparam int TAP_COUNT = 16;
  localparam int SEL_W = 4;
  localparam int POS_W = 24;
  localparam int FS_W = 16;

  localparam logic [14:0] ALIGN_CONTROL_ADDR = 15'h029;
  localparam logic [14:0] CLOCK_INPUT_CONFIG_ADDR = 15'h02A;
  localparam logic [14:0] SUPPLY_NOISE_CONTROL_ADDR = 15'h02B;
  localparam logic [14:0] EDGE_POSITION_ADDR = 15'h02C;
  localparam logic [14:0] FULL_SCALE_CODE_ADDR = 15'h030;
  localparam logic [14:0] POWER_PROFILE_A_ADDR = 15'h037;

  localparam logic [7:0] ALIGN_CONTROL_RESET = 8'h80;
  localparam logic [7:0] CLOCK_INPUT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SUPPLY_NOISE_CONTROL_RESET = 8'h10;
  localparam logic [23:0] EDGE_POSITION_RESET = 24'h000000;
  localparam logic [15:0] FULL_SCALE_CODE_RESET = 16'hA000;
  localparam logic [7:0] POWER_PROFILE_A_RESET = 8'h4B;

  localparam logic [7:0] POWER_CODE_LOW = 8'h46;
  localparam logic [7:0] POWER_CODE_HIGH_PERF = 8'h4B;

  localparam int INVERT_BIT = 0;
  localparam int ALIGN_PECL_BIT = 1;
  localparam int CLOCK_PECL_BIT = 2;
  localparam int CLOCK_RAIL_QUIET_BIT = 0;
  localparam int ANALOG_RAIL_QUIET_BIT = 2;
  localparam int DELAY_SEL_LSB = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } reg_request_type;

  typedef struct packed {
    logic clock_input_pecl_select;
    logic alignment_input_pecl_select;
    logic analog_rail_quiet_enable;
    logic clock_rail_quiet_enable;
    logic low_power_select;
    logic [15:0] full_scale_code;
  } analog_controls_type;
endpackage

// ---- core/alignment_tap_select.sv ----
// alignment reference tap choice, synchronisation and polarity
`timescale 1ns/1ps
module alignment_tap_select
  import clock_range_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [TAP_COUNT-1:0] alignment_taps,
  input wire logic [SEL_W-1:0] alignment_delay_select,
  input wire logic alignment_polarity_invert,
  output logic alignment_level,
  output logic alignment_rise
);
  logic [TAP_COUNT-1:0] tap_meta;
  logic [TAP_COUNT-1:0] tap_sync;
  logic next_level;
  logic next_rise;

  // every tap is synchronised so a late select change never sees a metastable bit
  always_comb begin
    next_level = tap_sync[alignment_delay_select] ^ alignment_polarity_invert;
    next_rise = next_level & ~alignment_level;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tap_meta <= '0;
      tap_sync <= '0;
      alignment_level <= 1'b0;
      alignment_rise <= 1'b0;
    end else begin
      tap_meta <= alignment_taps;
      tap_sync <= tap_meta;
      alignment_level <= next_level;
      alignment_rise <= next_rise;
    end
  end

  a_tap_polarity: assert property (@(posedge clk) disable iff (!rstn)
    alignment_level == ($past(tap_sync[alignment_delay_select]) ^ $past(alignment_polarity_invert)))
    else $error("alignment level does not follow selected tap and polarity");

  a_tap_select_path: assert property (@(posedge clk) disable iff (!rstn)
    $stable(alignment_delay_select) && !alignment_polarity_invert && $stable(alignment_polarity_invert)
    && $rose(tap_sync[alignment_delay_select]) |=> alignment_level)
    else $error("selected tap edge did not reach alignment level in one cycle");

  a_rise_pulse: assert property (@(posedge clk) disable iff (!rstn)
    alignment_rise |=> !alignment_rise)
    else $error("alignment rise held longer than one cycle");
endmodule

// ---- sim/config_host_model.sv ----
// host model that issues byte reads and writes to the register bank
`timescale 1ns/1ps
module config_host_model
  import clock_range_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output reg_request_type reg_req
);
  initial reg_req = '{wr: 1'b0, rd: 1'b0, addr: 15'h7FFF, wdata: 8'hFF};
  // an idle bus shows inverted values so a stale address never passes for a live one
  task automatic release_bus();
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~reg_req.addr, wdata: ~reg_req.wdata};
  endtask
  // reserved fields keep defaults, profile codes stay 0x46 or 0x4B unless refusal is meant
  // full-scale codes kept at or above 0x2000
  task automatic write_byte(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    release_bus();
  endtask
  // position bytes are read to choose the delay tap
  task automatic read_byte(input logic [14:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req.wdata};
    release_bus();
    @(posedge clk);
    d = reg_rdata;
  endtask
  // link and calibration enables live in other banks and are taken as already cleared
  // profiles b to d follow in other banks, then a calibration runs
  task automatic set_power_mode(input logic [7:0] code);
    write_byte(POWER_PROFILE_A_ADDR, code);
  endtask
endmodule

// ---- sim/clock_range_power_config_regs_bench.sv ----
// self-checking bench for the clock, range and power configuration registers
`timescale 1ns/1ps
module clock_range_power_config_regs_bench
  import clock_range_pkg::*;
;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] flags;
    logic [15:0] fs;
  } row_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  reg_request_type reg_req;
  logic [7:0] reg_rdata;
  logic [POS_W-1:0] edge_position_word = '0;
  logic edge_position_strobe = 1'b0;
  logic [TAP_COUNT-1:0] alignment_taps = '0;
  analog_controls_type controls;
  logic alignment_level;
  logic alignment_rise;
  int err_total = 0;
  int n_tests = 0;
  logic [7:0] rd;
  row_type rows [11];
  logic [14:0] ra [8] = '{15'h029, 15'h02A, 15'h02B, 15'h02C, 15'h02E, 15'h030, 15'h031,
    15'h037};
  logic [7:0] rv [8] = '{8'h80, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h4B};

  clock_range_power_config_regs dut (.clk(clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .edge_position_word(edge_position_word),
    .edge_position_strobe(edge_position_strobe), .alignment_taps(alignment_taps),
    .controls(controls), .alignment_level(alignment_level), .alignment_rise(alignment_rise));
  config_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_req(reg_req));

  initial forever #25 clk = ~clk;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end

  initial begin
    // flags: clock pecl, align pecl, analog quiet, clock quiet, low power
    rows = '{'{15'h02A, 8'h04, 8'h04, 5'h10, 16'hA000}, '{15'h02A, 8'h02, 8'h02, 5'h08, 16'hA000},
      '{15'h02B, 8'h14, 8'h14, 5'h0C, 16'hA000}, '{15'h02B, 8'h11, 8'h11, 5'h0A, 16'hA000},
      '{15'h030, 8'h34, 8'h34, 5'h0A, 16'hA034}, '{15'h031, 8'h20, 8'h20, 5'h0A, 16'h2034},
      '{15'h037, 8'h46, 8'h46, 5'h0B, 16'h2034}, '{15'h037, 8'h55, 8'h46, 5'h0B, 16'h2034},
      '{15'h037, 8'h4B, 8'h4B, 5'h0A, 16'h2034}, '{15'h02C, 8'hFF, 8'h00, 5'h0A, 16'h2034},
      '{15'h040, 8'hAA, 8'h00, 5'h0A, 16'h2034}};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      host.write_byte(rows[i].addr, rows[i].wdata);
      host.read_byte(rows[i].addr, rd);
      check("read back", {24'h0, rows[i].rdata}, {24'h0, rd});
      check("controls", {11'h0, rows[i].flags, rows[i].fs}, {11'h0, controls});
    end
    $display("row table done");
    @(posedge clk);
    edge_position_word <= 24'h5A3C96;
    edge_position_strobe <= 1'b1;
    fork
      begin
        @(posedge clk);
        edge_position_word <= 24'hA5C369;
        edge_position_strobe <= 1'b0;
      end
    join_none
    // read issued in the cycle right after the strobe: the capture must already be visible
    host.read_byte(EDGE_POSITION_ADDR + 15'h002, rd);
    check("position fresh", 32'h0000005A, {24'h0, rd});
    host.write_byte(15'h02D, 8'h00);
    for (int k = 0; k < 3; k++) begin
      host.read_byte(EDGE_POSITION_ADDR + 15'(k), rd);
      check("position byte", {24'h0, 8'(24'h5A3C96 >> (8 * k))}, {24'h0, rd});
    end
    $display("position capture done");
    // tap chosen before the reference edge arrives, so the path sees a steady select
    host.write_byte(ALIGN_CONTROL_ADDR, 8'h85);
    alignment_taps <= 16'h0020;
    for (int k = 0; k < 10 && alignment_rise !== 1'b1; k++) @(posedge clk);
    if (alignment_rise !== 1'b1) begin
      $display("[ERR] alignment rise expected 1 seen %b", alignment_rise);
      err_total++;
      complete_run();
    end
    check("tap five level", 32'h1, {31'h0, alignment_level});
    host.write_byte(CLOCK_INPUT_CONFIG_ADDR, 8'h01);
    repeat (3) @(posedge clk);
    check("inverted level", 32'h0, {31'h0, alignment_level});
    host.write_byte(ALIGN_CONTROL_ADDR, 8'h84);
    repeat (3) @(posedge clk);
    check("tap four inverted", 32'h1, {31'h0, alignment_level});
    $display("alignment path done");
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    // reset mid-run must restore the controls and the printed default of every register byte but 0x02D
    check("reset controls", 32'h0000A000, {11'h0, controls});
    rstn <= 1'b1;
    foreach (ra[i]) begin
      host.read_byte(ra[i], rd);
      check("reset value", {24'h0, rv[i]}, {24'h0, rd});
    end
    $display("reset values done");
    complete_run();
  end
endmodule
